// ==== hw/bcs_bus_cycle_status_decoder.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// RQ1: Input clock runs at twice the processor clock; one processor clock is two periods.
// RQ2: Inputs sampled and outputs updated only on the falling clock edge.
// RQ3: Both status inputs are active low; low means asserted.
// RQ4: A bus cycle starts when either status input is low at a falling edge.
// RQ5: Decode 000 inta, 001 io read, 010 io write, 011 idle, 100 halt, 101 mem read.
// RQ6: Memory select with status 10 is memory write, with 11 idle and no command; the code decodes 111 as BCS_NONE, not BCS_IDLE.
module bcs_bus_cycle_status_decoder
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Processor status pins
   input wire logic cycle_status_low_bit_n,
   input wire logic cycle_status_high_bit_n,
   input wire logic mem_io_select,
   // Decoded cycle towards command generation
   output bcs_pkg::bcs_decode_s decode
);

   // Raw pins gathered into one word, still asynchronous
   bcs_pkg::bcs_status_s pin_word;
   // Two synchroniser stages
   bcs_pkg::bcs_status_s sync1;
   bcs_pkg::bcs_status_s next_sync1;
   bcs_pkg::bcs_status_s sync2;
   bcs_pkg::bcs_status_s next_sync2;
   // Decode stage
   logic start_found;
   bcs_pkg::bcs_cycle_e type_found;
   logic next_start;
   bcs_pkg::bcs_cycle_e next_type;
   bcs_pkg::bcs_decode_s next_decode;

   // Either active-low status line low means a cycle is being started
   function automatic logic status_active
   (
      input bcs_pkg::bcs_status_s s
   );
      logic any_low;
      any_low = 1'b0;
      case ({s.cycle_status_high_bit_n, s.cycle_status_low_bit_n})
         2'h0:
         begin
            any_low = 1'b1; // RQ3
         end
         2'h1:
         begin
            any_low = 1'b1; // RQ3
         end
         2'h2:
         begin
            any_low = 1'b1; // RQ3
         end
         2'h3:
         begin
            any_low = 1'b0;
         end
         default:
         begin
            any_low = 1'b0;
         end
      endcase
      return any_low;
   endfunction

   // Cycle type from memory select and the status pair
   function automatic bcs_pkg::bcs_cycle_e cycle_of
   (
      input bcs_pkg::bcs_status_s s
   );
      bcs_pkg::bcs_cycle_e kind;
      kind = bcs_pkg::BCS_IDLE;
      if (s.mem_io_select)
      begin
         case ({s.cycle_status_high_bit_n, s.cycle_status_low_bit_n})
            2'h0:
            begin
               kind = bcs_pkg::BCS_HALT; // RQ5
            end
            2'h1:
            begin
               kind = bcs_pkg::BCS_MEMRD; // RQ5
            end
            2'h2:
            begin
               kind = bcs_pkg::BCS_MEMWR; // RQ6
            end
            2'h3:
            begin
               kind = bcs_pkg::BCS_NONE; // RQ6
            end
            default:
            begin
               kind = bcs_pkg::BCS_IDLE;
            end
         endcase
      end
      else
      begin
         case ({s.cycle_status_high_bit_n, s.cycle_status_low_bit_n})
            2'h0:
            begin
               kind = bcs_pkg::BCS_INTA; // RQ5
            end
            2'h1:
            begin
               kind = bcs_pkg::BCS_IORD; // RQ5
            end
            2'h2:
            begin
               kind = bcs_pkg::BCS_IOWR; // RQ5
            end
            2'h3:
            begin
               kind = bcs_pkg::BCS_IDLE; // RQ5
            end
            default:
            begin
               kind = bcs_pkg::BCS_IDLE;
            end
         endcase
      end
      return kind;
   endfunction

   // Pin gathering only; nothing here may be decoded yet
   always_comb
   begin
      pin_word.mem_io_select = mem_io_select;
      pin_word.cycle_status_high_bit_n = cycle_status_high_bit_n;
      pin_word.cycle_status_low_bit_n = cycle_status_low_bit_n;
   end

   // First stage; reset loads the idle level so no false start follows reset
   always_comb
   begin
      if (rst)
      begin
         next_sync1 = bcs_pkg::BCS_STATUS_RESET;
      end
      else
      begin
         next_sync1 = pin_word;
      end
   end

   // May be metastable, so only the second stage reads it
   always_ff @(negedge clock) // RQ2
   begin
      sync1 <= next_sync1;
   end

   // Second stage; the extra latency is the price of metastability safety
   always_comb
   begin
      if (rst)
      begin
         next_sync2 = bcs_pkg::BCS_STATUS_RESET;
      end
      else
      begin
         next_sync2 = sync1;
      end
   end

   always_ff @(negedge clock) // RQ2
   begin
      sync2 <= next_sync2;
   end

   // Decode of the settled sample
   always_comb
   begin
      start_found = status_active(sync2); // RQ4
      type_found = cycle_of(sync2); // RQ5 RQ6
   end

   // Start flag; a reset decode shows no cycle under way
   always_comb
   begin
      if (rst)
      begin
         next_start = bcs_pkg::BCS_DECODE_RESET.cycle_start;
      end
      else
      begin
         next_start = start_found;
      end
   end

   // Cycle type; reset shows idle so command logic stays quiet
   always_comb
   begin
      if (rst)
      begin
         next_type = bcs_pkg::BCS_DECODE_RESET.cycle_type;
      end
      else
      begin
         next_type = type_found;
      end
   end

   // Decode word assembled so the output is one register
   always_comb
   begin
      next_decode.cycle_start = next_start;
      next_decode.cycle_type = next_type;
   end

   // Doubled processor clock; the falling edge is the only active one.
   // Decode trails the pins by three falling edges; command timing must allow for it.
   always_ff @(negedge clock) // RQ1 RQ2
   begin
      decode <= next_decode;
   end

endmodule

// ==== pkg/bcs_pkg.sv ====
package bcs_pkg;

   // Decoded bus cycle type, coded as {memory select, status1, status0} active-low levels
   typedef enum logic [2:0] {
      BCS_INTA  = 3'h0,
      BCS_IORD  = 3'h1,
      BCS_IOWR  = 3'h2,
      BCS_IDLE  = 3'h3,
      BCS_HALT  = 3'h4,
      BCS_MEMRD = 3'h5,
      BCS_MEMWR = 3'h6,
      BCS_NONE  = 3'h7
   } bcs_cycle_e;

   // Raw status sample from the processor
   typedef struct packed {
      logic mem_io_select;
      logic cycle_status_high_bit_n;
      logic cycle_status_low_bit_n;
   } bcs_status_s;

   // Decoded result handed to command generation
   typedef struct packed {
      logic cycle_start;
      bcs_cycle_e cycle_type;
   } bcs_decode_s;

   localparam bcs_status_s BCS_STATUS_RESET = 3'h7;
   localparam bcs_decode_s BCS_DECODE_RESET = {1'b0, BCS_IDLE};

endpackage

// ==== bench/bcs_cpu.sv ====
`timescale 1ns/100ps
module bcs_cpu (
   input wire logic clock,
   input wire logic [2:0] code,
   output bcs_pkg::bcs_status_s pins = 3'h7);
   // Status moves on the rising edge, clear of the sampling edge
   always @(posedge clock) pins <= code;
endmodule

// ==== bench/bcs_props.sv ====
`timescale 1ns/100ps
module bcs_props (
   input wire logic clock, rst,
   input wire logic cycle_status_low_bit_n, cycle_status_high_bit_n, mem_io_select,
   input bcs_pkg::bcs_decode_s decode);
   default clocking @(negedge clock); endclocking
   default disable iff (rst);
   wire logic [2:0] pin = {mem_io_select, cycle_status_high_bit_n, cycle_status_low_bit_n};
   sequence s_low; !pin[0] || !pin[1]; endsequence
   sequence s_quiet; pin[1:0] == 2'h3; endsequence
   property p_low; !pin[0] |-> ##3 decode.cycle_start; endproperty
   property p_start; 1 |-> ##3 decode.cycle_start == ~&$past(pin[1:0], 3); endproperty
   property p_io; !pin[2] |-> ##3 decode.cycle_type == $past(pin, 3); endproperty
   property p_mem; pin[2] |-> ##3 decode.cycle_type == $past(pin, 3); endproperty
   property p_begin; s_low |-> ##3 decode.cycle_start; endproperty
   property p_quiet; s_quiet |-> ##3 !decode.cycle_start; endproperty
   property p_reset; disable iff (1'b0) rst |=> decode == bcs_pkg::BCS_DECODE_RESET; endproperty
   a_low: assert property (p_low) else $error("start missed");
   a_begin: assert property (p_begin) else $error("begin missed");
   a_quiet: assert property (p_quiet) else $error("false start");
   a_reset: assert property (p_reset) else $error("bad reset decode");
   a_start: assert property (p_start) else $error("bad start");
   a_io: assert property (p_io) else $error("bad io type");
   a_mem: assert property (p_mem) else $error("bad mem type");
endmodule
bind bcs_bus_cycle_status_decoder bcs_props i_bcs_props (.*);

// ==== bench/bcs_bus_cycle_status_decoder_test.sv ====
`timescale 1ns/100ps
module bcs_bus_cycle_status_decoder_test;
   logic clock = 0, rst = 1;
   logic [2:0] code = 3'h7;
   bcs_pkg::bcs_status_s pins;
   bcs_pkg::bcs_decode_s decode;
   int err_total = 0, check_count = 0;
   bcs_cpu i_bcs_cpu (.clock(clock), .code(code), .pins(pins));
   bcs_bus_cycle_status_decoder i_bcs_bus_cycle_status_decoder (.clock(clock), .rst(rst),
      .cycle_status_low_bit_n(pins[0]), .cycle_status_high_bit_n(pins[1]),
      .mem_io_select(pins[2]), .decode(decode));
   initial forever #10 clock = ~clock;
   function automatic logic [3:0] expect_of(logic [2:0] c);
      return {~&c[1:0], c};
   endfunction
   task automatic check(logic [3:0] seen, logic [3:0] want);
      check_count++;
      if (seen !== want) err_total++;
      if (seen !== want) $display("wrong value at %0t: %h %h", $time, seen, want);
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      void'($urandom(13));
      repeat (2) @(posedge clock);
      rst <= 0;
      // Every code first, then random ones
      for (int i = 0; i < 48; i++)
      begin
         @(posedge clock) code <= (i < 8) ? i[2:0] : 3'($urandom);
         @(posedge clock);
         repeat (3) @(negedge clock);
         #1 check(decode, expect_of(code));
      end
      $display("decode test done");
      conclude;
   end
   initial
   begin
      #20000 err_total++;
      conclude;
   end
endmodule
